// [rtl/hsct_timing_ctrl.sv]
// top of the sync timing and control register block
// assumes the pixel clock is clk_sys_i; the analog pll, phase delay line,
// converters and clamp switches sit outside and take these settings
`timescale 1ns/10ps

// Summary of operation
// - sampling clock follows hsync; phase settable over a full period in 32 steps.
// - phase field bits 7:3 delays sampling by one thirty-second period per count.
// - incoming hsync polarity is detected; output polarity chosen by sync control bit 5.
// - output sync stays aligned with output data clock and pixel data.
// - output sync active for the pixel count in the width register, reset 32.
// - coast is asynchronous and freezes pll reference while asserted.
// - divider bits 11:4 come from the divider high register, reset 0x69.
// - divider low register bits 7:4 give divider bits 3:0, reset 1101.
// - vco range bits 7:6 and pump current bits 5:3, reset 01 and 001.
// - clamp starts the programmed pixel count after hsync trailing edge, reset 128.
// - clamp stays active for the count in the clamp length register.
// - three 8-bit channel range registers, each resetting to 128.
// - red level shift holds a 7-bit offset in bits 7:1, reset 1000000.
// - read-only silicon revision at address zero; writes ignored.
// - host reads and writes registers over the two-wire port; contents drive modes.
// - each phase step is 1/32 cycle; output sync gets the same phase shift.
// - polarity bit 0 gives active-high output sync, 1 gives active-low.
// - four data sets come out of the pipeline before valid data.
module hsct_timing_ctrl #(
	parameter logic [7:0] REVISION = 8'h01, // arbitrary value
	parameter logic [6:0] DEV_ADDR = 7'h4C, // arbitrary value
	parameter int         PIX_W    = 24
) (
	input  wire logic             clk_sys_i,
	input  wire logic             srst_i,
	input  wire logic             scl_i,
	input  wire logic             sda_i,
	output logic                  sda_o,
	output logic                  sda_oe_n_o,
	input  wire logic             hsync_i,
	input  wire logic             coast_i,
	input  wire logic [PIX_W-1:0] pixel_in_i,
	output logic [PIX_W-1:0]      pixel_out_o,
	output logic                  pixel_valid_o,
	output logic                  line_sync_out_o,
	output logic                  clamp_o,
	output logic                  pll_ref_o,
	output logic                  pll_ref_en_o,
	output logic [11:0]           pll_divider_o,
	output logic [1:0]            vco_range_o,
	output logic [2:0]            pump_current_o,
	output logic [4:0]            sample_phase_o,
	output logic [4:0]            sync_phase_o,
	output logic [7:0]            red_range_o,
	output logic [7:0]            green_range_o,
	output logic [7:0]            blue_range_o,
	output logic [6:0]            red_level_shift_o
);
	localparam int PD = hsct_pkg::PIPE_DEPTH;

	typedef struct packed {
		logic [7:0]                div_high;
		logic [3:0]                div_low;
		logic [1:0]                vco;
		logic [2:0]                pump;
		logic [4:0]                phase;
		logic [7:0]                clamp_start;
		logic [7:0]                clamp_len;
		logic [7:0]                sync_width;
		logic [2:0][7:0]           range;
		logic [6:0]                red_shift;
		logic [7:0]                sync_ctrl;
		logic                      coast_s1;
		logic                      coast_s2;
		logic                      ref_en;
		logic                      ref_lvl;
		logic                      clamp;
		logic [PD-1:0]             sync_pipe;
		logic [PD-1:0][PIX_W-1:0]  pix_pipe;
		logic [2:0]                flush;
		logic                      valid;
	} hsct_top_t;

	hsct_top_t  r;
	hsct_top_t  n;
	logic       wr;
	logic [7:0] wr_addr;
	logic [7:0] wr_data;
	logic [7:0] rd_addr;
	logic [7:0] rd_data;
	logic       sync_act;
	logic       clamp_act;
	logic       pol_high;
	logic       lead;

	// register readback; unmapped addresses read zero
	function automatic logic [7:0] hsct_read(input logic [7:0] a, input hsct_top_t s);
		case (a)
			hsct_pkg::REG_REVISION:    hsct_read = REVISION;
			hsct_pkg::REG_DIV_HIGH:    hsct_read = s.div_high;
			hsct_pkg::REG_DIV_LOW:     hsct_read = {s.div_low, 4'h0};
			hsct_pkg::REG_VCO_PUMP:    hsct_read = {s.vco, s.pump, 3'h0};
			hsct_pkg::REG_PHASE:       hsct_read = {s.phase, 3'h0};
			hsct_pkg::REG_CLAMP_START: hsct_read = s.clamp_start;
			hsct_pkg::REG_CLAMP_LEN:   hsct_read = s.clamp_len;
			hsct_pkg::REG_SYNC_WIDTH:  hsct_read = s.sync_width;
			hsct_pkg::REG_RED_RANGE:   hsct_read = s.range[0];
			hsct_pkg::REG_GREEN_RANGE: hsct_read = s.range[1];
			hsct_pkg::REG_BLUE_RANGE:  hsct_read = s.range[2];
			hsct_pkg::REG_RED_SHIFT:   hsct_read = {s.red_shift, 1'b0};
			hsct_pkg::REG_SYNC_CTRL:   hsct_read = s.sync_ctrl;
			default:                   hsct_read = 8'h00;
		endcase
	endfunction : hsct_read

	assign rd_data = hsct_read(rd_addr, r);

	hsct_twowire_slave #(
		.DEV_ADDR (DEV_ADDR)
	) u_port (
		.clk_sys_i  (clk_sys_i),
		.srst_i     (srst_i),
		.scl_i      (scl_i),
		.sda_i      (sda_i),
		.rd_data_i  (rd_data),
		.sda_o      (sda_o),
		.sda_oe_n_o (sda_oe_n_o),
		.wr_o       (wr),
		.wr_addr_o  (wr_addr),
		.wr_data_o  (wr_data),
		.rd_addr_o  (rd_addr)
	);

	hsct_line_timer #(
		.CW (8)
	) u_timer (
		.clk_sys_i     (clk_sys_i),
		.srst_i        (srst_i),
		.hsync_i       (hsync_i),
		.width_i       (r.sync_width),
		.clamp_start_i (r.clamp_start),
		.clamp_len_i   (r.clamp_len),
		.sync_act_o    (sync_act),
		.clamp_act_o   (clamp_act),
		.pol_high_o    (pol_high),
		.lead_o        (lead)
	);

	// register writes, coast crossing and the output pipeline
	always_comb begin
		n = r;
		if (wr) begin
			case (wr_addr)
				hsct_pkg::REG_DIV_HIGH:    n.div_high = wr_data;
				hsct_pkg::REG_DIV_LOW:     n.div_low = wr_data[7:4];
				hsct_pkg::REG_VCO_PUMP: begin
					n.vco  = wr_data[7:6];
					n.pump = wr_data[5:3];
				end
				hsct_pkg::REG_PHASE:       n.phase = wr_data[7:3];
				hsct_pkg::REG_CLAMP_START: n.clamp_start = wr_data;
				hsct_pkg::REG_CLAMP_LEN:   n.clamp_len = wr_data;
				hsct_pkg::REG_SYNC_WIDTH:  n.sync_width = wr_data;
				hsct_pkg::REG_RED_RANGE:   n.range[0] = wr_data;
				hsct_pkg::REG_GREEN_RANGE: n.range[1] = wr_data;
				hsct_pkg::REG_BLUE_RANGE:  n.range[2] = wr_data;
				hsct_pkg::REG_RED_SHIFT:   n.red_shift = wr_data[7:1];
				hsct_pkg::REG_SYNC_CTRL:   n.sync_ctrl = wr_data;
				default: ; // revision and unmapped writes are dropped
			endcase
		end
		// coast arrives asynchronously, so it crosses in two flops first
		n.coast_s1 = coast_i;
		n.coast_s2 = r.coast_s1;
		n.ref_en   = ~r.coast_s2;
		n.ref_lvl  = ~r.coast_s2 & (hsync_i == pol_high);
		n.clamp    = clamp_act;
		// sync rides the same pipeline depth as the pixels
		n.sync_pipe = {r.sync_pipe[PD-2:0],
			sync_act ^ r.sync_ctrl[hsct_pkg::SYNC_OUT_POL_BIT]};
		n.pix_pipe  = {r.pix_pipe[PD-2:0], pixel_in_i};
		// the first sets out of the pipeline are stale and flagged invalid
		n.flush = (r.flush == hsct_pkg::FLUSH_SETS) ? r.flush : 3'(r.flush + 3'h1);
		n.valid = n.flush == hsct_pkg::FLUSH_SETS;
	end

	always_ff @(posedge clk_sys_i) begin
		if (srst_i) begin
			r             <= '0;
			r.div_high    <= hsct_pkg::RST_DIV_HIGH;
			r.div_low     <= hsct_pkg::RST_DIV_LOW;
			r.vco         <= hsct_pkg::RST_VCO;
			r.pump        <= hsct_pkg::RST_PUMP;
			r.phase       <= hsct_pkg::RST_PHASE;
			r.clamp_start <= hsct_pkg::RST_CLAMP_START;
			r.clamp_len   <= hsct_pkg::RST_CLAMP_LEN;
			r.sync_width  <= hsct_pkg::RST_SYNC_WIDTH;
			r.range       <= {3{hsct_pkg::RST_RANGE}};
			r.red_shift   <= hsct_pkg::RST_RED_SHIFT;
			r.sync_ctrl   <= hsct_pkg::RST_SYNC_CTRL;
			r.ref_en      <= 1'b1;
		end else begin
			r <= n;
		end
	end

	// every output is a register field; phase feeds both delay lines
	assign pixel_out_o       = r.pix_pipe[PD-1];
	assign pixel_valid_o     = r.valid;
	assign line_sync_out_o   = r.sync_pipe[PD-1];
	assign clamp_o           = r.clamp;
	assign pll_ref_o         = r.ref_lvl;
	assign pll_ref_en_o      = r.ref_en;
	assign pll_divider_o     = {r.div_high, r.div_low};
	assign vco_range_o       = r.vco;
	assign pump_current_o    = r.pump;
	assign sample_phase_o    = r.phase;
	assign sync_phase_o      = r.phase;
	assign red_range_o       = r.range[0];
	assign green_range_o     = r.range[1];
	assign blue_range_o      = r.range[2];
	assign red_level_shift_o = r.red_shift;

	// helper: length of the current active output sync run
	logic [8:0] sync_run;
	logic       sync_on;
	assign sync_on = line_sync_out_o ^ r.sync_ctrl[hsct_pkg::SYNC_OUT_POL_BIT];
	always_ff @(posedge clk_sys_i) begin
		if (srst_i)
			sync_run <= 9'h000;
		else
			sync_run <= sync_on ? 9'(sync_run + 9'h001) : 9'h000;
	end

	property p_div_high;
		@(posedge clk_sys_i) disable iff (srst_i)
		wr && wr_addr == hsct_pkg::REG_DIV_HIGH |=> pll_divider_o[11:4] == $past(wr_data);
	endproperty
	a_div_high: assert property (p_div_high) else $error("divider high not applied");

	property p_div_low;
		@(posedge clk_sys_i) disable iff (srst_i)
		wr && wr_addr == hsct_pkg::REG_DIV_LOW |=> pll_divider_o[3:0] == $past(wr_data[7:4]);
	endproperty
	a_div_low: assert property (p_div_low) else $error("divider low not applied");

	property p_vco_pump;
		@(posedge clk_sys_i) disable iff (srst_i)
		wr && wr_addr == hsct_pkg::REG_VCO_PUMP |=>
			{vco_range_o, pump_current_o} == $past(wr_data[7:3]);
	endproperty
	a_vco_pump: assert property (p_vco_pump) else $error("vco or pump not applied");

	property p_phase;
		@(posedge clk_sys_i) disable iff (srst_i)
		wr && wr_addr == hsct_pkg::REG_PHASE |=>
			sample_phase_o == $past(wr_data[7:3]) && sync_phase_o == sample_phase_o;
	endproperty
	a_phase: assert property (p_phase) else $error("phase not applied to both");

	property p_revision;
		@(posedge clk_sys_i) disable iff (srst_i)
		rd_addr == hsct_pkg::REG_REVISION |-> rd_data == REVISION;
	endproperty
	a_revision: assert property (p_revision) else $error("revision readback wrong");

	property p_coast;
		@(posedge clk_sys_i) disable iff (srst_i)
		coast_i [*3] |=> !pll_ref_en_o && !pll_ref_o;
	endproperty
	a_coast: assert property (p_coast) else $error("reference not frozen by coast");

	property p_flush;
		@(posedge clk_sys_i) disable iff (srst_i)
		$fell(srst_i) |-> !pixel_valid_o [*4] ##1 pixel_valid_o;
	endproperty
	a_flush: assert property (p_flush) else $error("flush count wrong");

	property p_align;
		@(posedge clk_sys_i) disable iff (srst_i)
		pixel_valid_o |-> pixel_out_o == $past(pixel_in_i, 4);
	endproperty
	a_align: assert property (p_align) else $error("pixel pipeline depth wrong");

	// polarity is the one in force when the sample entered the pipeline
	property p_sync_pol;
		@(posedge clk_sys_i) disable iff (srst_i)
		pixel_valid_o |-> line_sync_out_o ==
			($past(sync_act, 4) ^ $past(r.sync_ctrl[hsct_pkg::SYNC_OUT_POL_BIT], 4));
	endproperty
	a_sync_pol: assert property (p_sync_pol) else $error("output sync polarity wrong");

	// a polarity flip shows a short false run until the pipeline catches up
	property p_sync_width;
		@(posedge clk_sys_i) disable iff (srst_i)
		$fell(sync_on) && $stable(r.sync_width) && $past(r.sync_ctrl, 5) == r.sync_ctrl |->
			sync_run == {1'b0, r.sync_width};
	endproperty
	a_sync_width: assert property (p_sync_width) else $error("output sync width wrong");

	c_write:  cover property (@(posedge clk_sys_i) disable iff (srst_i) wr);
	c_coast:  cover property (@(posedge clk_sys_i) disable iff (srst_i) $fell(pll_ref_en_o));
	c_clamp:  cover property (@(posedge clk_sys_i) disable iff (srst_i) $rose(clamp_o));
	c_sync:   cover property (@(posedge clk_sys_i) disable iff (srst_i) lead ##1 sync_act);
endmodule : hsct_timing_ctrl

// [rtl/hsct_pkg.sv]
// constants shared by the sync timing and control register block
// assumes a single pixel-rate clock and synchronous active-high reset
package hsct_pkg;
	// register offsets
	localparam logic [7:0] REG_REVISION    = 8'h00;
	localparam logic [7:0] REG_DIV_HIGH    = 8'h01;
	localparam logic [7:0] REG_DIV_LOW     = 8'h02;
	localparam logic [7:0] REG_VCO_PUMP    = 8'h03;
	localparam logic [7:0] REG_PHASE       = 8'h04;
	localparam logic [7:0] REG_CLAMP_START = 8'h05;
	localparam logic [7:0] REG_CLAMP_LEN   = 8'h06;
	localparam logic [7:0] REG_SYNC_WIDTH  = 8'h07;
	localparam logic [7:0] REG_RED_RANGE   = 8'h08;
	localparam logic [7:0] REG_GREEN_RANGE = 8'h09;
	localparam logic [7:0] REG_BLUE_RANGE  = 8'h0A;
	localparam logic [7:0] REG_RED_SHIFT   = 8'h0B;
	localparam logic [7:0] REG_SYNC_CTRL   = 8'h0E;
	// values after reset
	localparam logic [7:0] RST_DIV_HIGH    = 8'h69;
	localparam logic [3:0] RST_DIV_LOW     = 4'hD;
	localparam logic [1:0] RST_VCO         = 2'h1;
	localparam logic [2:0] RST_PUMP        = 3'h1;
	localparam logic [4:0] RST_PHASE       = 5'h10;
	localparam logic [7:0] RST_CLAMP_START = 8'h80;
	localparam logic [7:0] RST_CLAMP_LEN   = 8'h80;
	localparam logic [7:0] RST_SYNC_WIDTH  = 8'h20;
	localparam logic [7:0] RST_RANGE       = 8'h80;
	localparam logic [6:0] RST_RED_SHIFT   = 7'h40;
	localparam logic [7:0] RST_SYNC_CTRL   = 8'h40;
	// field positions
	localparam int SYNC_OUT_POL_BIT = 5;
	// output pipeline: data sets presented before valid data
	localparam int          PIPE_DEPTH  = 4;
	localparam logic [2:0]  FLUSH_SETS  = 3'h4;
endpackage : hsct_pkg

// [rtl/hsct_twowire_slave.sv]
// two-wire serial slave: device byte, register pointer, data bytes
// assumes scl and sda already synchronous to clk_sys_i; sda is open drain
`timescale 1ns/10ps
module hsct_twowire_slave #(
	parameter logic [6:0] DEV_ADDR = 7'h4C // arbitrary value
) (
	input  wire logic       clk_sys_i,
	input  wire logic       srst_i,
	input  wire logic       scl_i,
	input  wire logic       sda_i,
	input  wire logic [7:0] rd_data_i,
	output logic            sda_o,
	output logic            sda_oe_n_o,
	output logic            wr_o,
	output logic [7:0]      wr_addr_o,
	output logic [7:0]      wr_data_o,
	output logic [7:0]      rd_addr_o
);
	typedef enum logic [2:0] {S_IDLE, S_RX, S_ACKQ, S_ACK, S_TX, S_MACK} hsct_tw_state_t;
	typedef enum logic [1:0] {K_DEV, K_PTR, K_DAT} hsct_tw_kind_t;
	typedef struct packed {
		hsct_tw_state_t st;
		hsct_tw_kind_t  kind;
		logic           rw;
		logic [2:0]     cnt;
		logic [7:0]     sh;
		logic [7:0]     ptr;
		logic           drv;
		logic           wr;
		logic [7:0]     waddr;
		logic [7:0]     wdata;
		logic           scl_q;
		logic           sda_q;
	} hsct_tw_t;

	hsct_tw_t r;
	hsct_tw_t n;
	logic     rise;
	logic     fall;
	logic     start;
	logic     stop;
	logic [7:0] byte_in;

	// bus conditions from the previous sampled levels
	assign rise    = scl_i & ~r.scl_q;
	assign fall    = ~scl_i & r.scl_q;
	assign start   = scl_i & r.scl_q & r.sda_q & ~sda_i;
	assign stop    = scl_i & r.scl_q & ~r.sda_q & sda_i;
	assign byte_in = {r.sh[6:0], sda_i};

	// protocol sequencer; sda only changes after scl falls to keep setup
	always_comb begin
		n       = r;
		n.wr    = 1'b0;
		n.scl_q = scl_i;
		n.sda_q = sda_i;
		if (start) begin
			n.st   = S_RX;
			n.kind = K_DEV;
			n.cnt  = 3'h0;
			n.drv  = 1'b0;
		end else if (stop) begin
			n.st  = S_IDLE;
			n.drv = 1'b0;
		end else begin
			case (r.st)
				S_RX: if (rise) begin
					n.sh  = byte_in;
					n.cnt = 3'(r.cnt + 3'h1);
					if (r.cnt == 3'h7) begin
						n.st = S_ACKQ;
						case (r.kind)
							K_DEV: begin
								n.rw   = sda_i;
								n.kind = K_PTR;
								if (r.sh[6:0] != DEV_ADDR)
									n.st = S_IDLE; // not addressed: stay silent
							end
							K_PTR: begin
								n.ptr  = byte_in;
								n.kind = K_DAT;
							end
							default: begin
								n.wr    = 1'b1;
								n.waddr = r.ptr;
								n.wdata = byte_in;
								n.ptr   = 8'(r.ptr + 8'h01);
							end
						endcase
					end
				end
				S_ACKQ: if (fall) begin
					n.drv = 1'b1;
					n.st  = S_ACK;
				end
				S_ACK: if (fall) begin
					n.cnt = 3'h0;
					if (r.rw) begin
						n.sh  = rd_data_i;
						n.ptr = 8'(r.ptr + 8'h01);
						n.drv = ~rd_data_i[7];
						n.st  = S_TX;
					end else begin
						n.drv = 1'b0;
						n.st  = S_RX;
					end
				end
				S_TX: if (fall) begin
					n.cnt = 3'(r.cnt + 3'h1);
					if (r.cnt == 3'h7) begin
						n.drv = 1'b0;
						n.st  = S_MACK;
					end else begin
						n.sh  = {r.sh[6:0], 1'b0};
						n.drv = ~r.sh[6];
					end
				end
				S_MACK: if (rise)
					n.st = sda_i ? S_IDLE : S_ACK; // master nack ends the read
				default: n.st = S_IDLE;
			endcase
		end
	end

	always_ff @(posedge clk_sys_i) begin
		if (srst_i) begin
			r <= '{st: S_IDLE, kind: K_DEV, scl_q: 1'b1, sda_q: 1'b1, default: '0};
		end else begin
			r <= n;
		end
	end

	assign sda_o      = 1'b0;
	assign sda_oe_n_o = ~r.drv;
	assign wr_o       = r.wr;
	assign wr_addr_o  = r.waddr;
	assign wr_data_o  = r.wdata;
	assign rd_addr_o  = r.ptr;
endmodule : hsct_twowire_slave

// [rtl/hsct_line_timer.sv]
// horizontal sync polarity detect, output sync width and clamp timing
// assumes hsync_i synchronous to the pixel clock; counts in pixel clocks
`timescale 1ns/10ps
module hsct_line_timer #(
	parameter int CW = 8
) (
	input  wire logic          clk_sys_i,
	input  wire logic          srst_i,
	input  wire logic          hsync_i,
	input  wire logic [CW-1:0] width_i,
	input  wire logic [CW-1:0] clamp_start_i,
	input  wire logic [CW-1:0] clamp_len_i,
	output logic               sync_act_o,
	output logic               clamp_act_o,
	output logic               pol_high_o,
	output logic               lead_o
);
	typedef struct packed {
		logic          hs_q;
		logic [15:0]   run;
		logic [15:0]   hi_len;
		logic [15:0]   lo_len;
		logic          pol_high;
		logic [CW-1:0] sync_cnt;
		logic [CW-1:0] dly;
		logic          wait_f;
		logic [CW-1:0] clamp_cnt;
	} hsct_lt_t;

	hsct_lt_t r;
	hsct_lt_t n;
	logic     edge_f;
	logic     lead;
	logic     trail;

	assign edge_f = hsync_i != r.hs_q;
	assign lead   = edge_f & (hsync_i == r.pol_high);
	assign trail  = edge_f & (hsync_i != r.pol_high);

	// the shorter of the two levels is taken as the active pulse
	always_comb begin
		n      = r;
		n.hs_q = hsync_i;
		n.run  = edge_f ? 16'h0001 : ((&r.run) ? r.run : 16'(r.run + 16'h0001));
		if (edge_f) begin
			if (r.hs_q)
				n.hi_len = r.run;
			else
				n.lo_len = r.run;
		end
		n.pol_high = n.hi_len < n.lo_len;
		// output sync width restarts on every leading edge
		if (lead)
			n.sync_cnt = width_i;
		else if (r.sync_cnt != '0)
			n.sync_cnt = CW'(r.sync_cnt - 1'b1);
		// clamp waits its placement from the trailing edge, then runs its length
		if (trail) begin
			n.wait_f    = 1'b1;
			n.dly       = clamp_start_i;
			n.clamp_cnt = '0;
		end else if (r.wait_f) begin
			if (r.dly == '0) begin
				n.wait_f    = 1'b0;
				n.clamp_cnt = clamp_len_i;
			end else begin
				n.dly = CW'(r.dly - 1'b1);
			end
		end else if (r.clamp_cnt != '0) begin
			n.clamp_cnt = CW'(r.clamp_cnt - 1'b1);
		end
	end

	always_ff @(posedge clk_sys_i) begin
		if (srst_i) begin
			r <= '0;
		end else begin
			r <= n;
		end
	end

	// sync is a next-state view so the top can register it in step with the data
	assign sync_act_o  = n.sync_cnt != '0;
	assign clamp_act_o = r.clamp_cnt != '0;
	assign pol_high_o  = r.pol_high;
	assign lead_o      = lead;
endmodule : hsct_line_timer

// [testbench/hsct_host_model.sv]
// serial host model: drives clock and data of the two-wire register port
// assumes a pull-up on the data wire and a device sampling every clk edge
`timescale 1ns/10ps
module hsct_host_model #(
	parameter logic [6:0] DEV_ADDR = 7'h4C
) (
	input  wire logic clk_sys_i,
	input  wire logic sda_o,
	input  wire logic sda_oe_n_o,
	output logic      scl_o,
	output logic      sda_line_o
);
	logic sda_m;
	// wired-and of both parties; released wire floats to the pull-up level
	assign sda_line_o = sda_m & (sda_oe_n_o | sda_o);
	initial begin
		scl_o = 1'b1;
		sda_m = 1'b1;
	end
	// data moves only while the clock is low, so no false start or stop
	task automatic bitx(input logic d, output logic q);
		scl_o <= 1'b0;
		@(posedge clk_sys_i);
		sda_m <= d;
		repeat (2) @(posedge clk_sys_i);
		scl_o <= 1'b1;
		repeat (2) @(posedge clk_sys_i);
		q = sda_line_o;
		@(posedge clk_sys_i);
	endtask : bitx
	// start when fin is 0, stop when fin is 1
	task automatic cond(input logic fin);
		scl_o <= 1'b0;
		@(posedge clk_sys_i);
		sda_m <= ~fin;
		repeat (2) @(posedge clk_sys_i);
		scl_o <= 1'b1;
		repeat (3) @(posedge clk_sys_i);
		sda_m <= fin;
		repeat (3) @(posedge clk_sys_i);
	endtask : cond
	// byte msb first, then the ninth bit
	task automatic xbyte(input logic [7:0] tx, output logic [7:0] rx, output logic ack);
		for (int i = 7; i >= 0; i--) bitx(tx[i], rx[i]);
		bitx(1'b1, ack);
	endtask : xbyte
	// write n bytes from the top of dv, pointer auto-increments
	task automatic wr(input logic [7:0] a, input logic [31:0] dv, input int n, output logic ok);
		logic [7:0] r;
		logic       k;
		cond(1'b0);
		xbyte({DEV_ADDR, 1'b0}, r, k);
		ok = ~k;
		xbyte(a, r, k);
		ok &= ~k;
		for (int i = 0; i < n; i++) begin
			xbyte(dv[31-8*i -: 8], r, k);
			ok &= ~k;
		end
		cond(1'b1);
	endtask : wr
	// pointer write, repeated start, one byte read closed by a nack
	task automatic rd(input logic [7:0] a, output logic [7:0] d, output logic ok);
		logic k;
		cond(1'b0);
		xbyte({DEV_ADDR, 1'b0}, d, k);
		ok = ~k;
		xbyte(a, d, k);
		ok &= ~k;
		cond(1'b0);
		xbyte({DEV_ADDR, 1'b1}, d, k);
		ok &= ~k;
		xbyte(8'hFF, d, k);
		cond(1'b1);
	endtask : rd
endmodule : hsct_host_model

// [testbench/tb_hsct_timing_ctrl.sv]
// self-checking bench of the sync timing and control register block
// assumes the host model owns the serial port; bench drives sync and pixels
`timescale 1ns/10ps
module tb_hsct_timing_ctrl;
	localparam logic [7:0] REV = 8'h01; // arbitrary value
	localparam logic [7:0] RST_TAB [15] = '{8'h01, 8'h69, 8'hD0, 8'h48, 8'h80, 8'h80,
		8'h80, 8'h20, 8'h80, 8'h80, 8'h80, 8'h80, 8'h00, 8'h00, 8'h40};
	logic        clk_sys_i, srst_i, scl_i, sda_i, sda_o, sda_oe_n_o, hsync_i, coast_i;
	logic        pixel_valid_o, line_sync_out_o, clamp_o, pll_ref_o, pll_ref_en_o, ok;
	logic [23:0] pixel_in_i, pixel_out_o, pix, pe;
	logic [23:0] exp_q[$];
	logic [11:0] pll_divider_o;
	logic [1:0]  vco_range_o;
	logic [2:0]  pump_current_o;
	logic [4:0]  sample_phase_o, sync_phase_o;
	logic [7:0]  red_range_o, green_range_o, blue_range_o, d;
	logic [6:0]  red_level_shift_o;
	logic [31:0] v;
	int          num_errors = 0;
	int          n_tests = 0;
	int          ns, nc, nr, dc, dc0, s, s0, l, w, k;
	hsct_timing_ctrl #(.REVISION(REV)) dut (.*);
	hsct_host_model u_host (.clk_sys_i, .sda_o, .sda_oe_n_o, .scl_o(scl_i), .sda_line_o(sda_i));
	initial begin
		clk_sys_i = 1'b0;
		forever #2.5 clk_sys_i = ~clk_sys_i;
	end
	task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
		n_tests++;
		if (got !== exp) begin
			$display("MISMATCH t=%0t %s", $time, m);
			num_errors++;
		end
	endtask : chk
	task automatic wrap_up;
		$display("checks %0d errors %0d", n_tests, num_errors);
		if (num_errors == 0 && n_tests > 0) $display("All checks passed");
		else $display("Checks failed");
		$finish;
	endtask : wrap_up
	// fresh random pixel each clock, noted for the watcher
	always @(posedge clk_sys_i) begin
		pix = 24'($urandom);
		pixel_in_i <= pix;
		exp_q.push_back(pix);
	end
	// a pixel shows four clocks after it went in; flushed sets are skipped
	always @(negedge clk_sys_i) begin
		if (exp_q.size() == 5) begin
			pe = exp_q.pop_front();
			if (pixel_valid_o === 1'b1) chk(pixel_out_o, pe, "pixel");
		end
	end
	// one line: 10 clocks of sync (low when inv), 60 idle; counts what comes out
	task automatic meas_line(input logic act, input logic inv);
		ns = 0;
		nc = 0;
		nr = 0;
		dc = -1;
		for (int c = 0; c < 70; c++) begin
			hsync_i <= (c < 10) ^ inv;
			@(posedge clk_sys_i);
			if (line_sync_out_o === act) ns++;
			if (pll_ref_o === 1'b1) nr++;
			if (clamp_o === 1'b1) begin
				nc++;
				if (dc < 0) dc = c;
			end
		end
	endtask : meas_line
	initial begin
		void'($urandom(86));
		srst_i = 1'b1;
		hsync_i = 1'b0;
		coast_i = 1'b0;
		pixel_in_i = 24'h0;
		repeat (3) @(posedge clk_sys_i);
		srst_i <= 1'b0;
		@(posedge clk_sys_i);
		// reset contents, reserved bits and two unmapped places
		for (int a = 0; a < 15; a++) begin
			u_host.rd(8'(a), d, ok);
			chk(ok, 1, "ack");
			chk(d, RST_TAB[a], "reset value");
		end
		// divider written high byte first, then vco, pump and phase
		v = $urandom;
		u_host.wr(hsct_pkg::REG_DIV_HIGH, v, 4, ok);
		chk(ok, 1, "write ack");
		chk(pll_divider_o, {v[31:24], v[23:20]}, "divider");
		chk(vco_range_o, v[15:14], "vco");
		chk(pump_current_o, v[13:11], "pump");
		chk(sample_phase_o, v[7:3], "phase");
		chk(sync_phase_o, v[7:3], "sync phase");
		u_host.rd(hsct_pkg::REG_DIV_LOW, d, ok);
		chk(d, {v[23:20], 4'h0}, "low readback");
		// revision ignores writes
		u_host.wr(hsct_pkg::REG_REVISION, {~REV, 24'h0}, 1, ok);
		u_host.rd(hsct_pkg::REG_REVISION, d, ok);
		chk(d, REV, "revision");
		v = $urandom;
		u_host.wr(hsct_pkg::REG_RED_RANGE, v, 4, ok);
		chk({red_range_o, green_range_o, blue_range_o, red_level_shift_o}, v[31:1], "ranges");
		// sync width and clamp timing in both output polarities, then an active-low input
		for (int p = 0; p < 3; p++) begin
			s = $urandom_range(8, 1);
			l = $urandom_range(20, 1);
			w = $urandom_range(20, 1);
			u_host.wr(hsct_pkg::REG_CLAMP_START, {8'(s), 8'(l), 8'(w), 8'h0}, 3, ok);
			u_host.wr(hsct_pkg::REG_SYNC_CTRL, {8'h40 | 8'((p & 1) * 32), 24'h0}, 1, ok);
			repeat (3) meas_line(p != 1, p == 2);
			chk(ns, w, "sync width");
			chk(nc, l, "clamp length");
			chk(nr, 10, "reference");
			if (p > 0) chk(dc - dc0, s - s0, "clamp place");
			dc0 = dc;
			s0 = s;
		end
		// coast drops the reference, release restores it
		coast_i <= 1'b1;
		for (k = 0; k < 8 && pll_ref_en_o !== 1'b0; k++) @(posedge clk_sys_i);
		chk(pll_ref_en_o, 0, "coast");
		chk(pll_ref_o, 0, "ref gated");
		coast_i <= 1'b0;
		for (k = 0; k < 8 && pll_ref_en_o !== 1'b1; k++) @(posedge clk_sys_i);
		chk(pll_ref_en_o, 1, "coast off");
		wrap_up();
	end
endmodule : tb_hsct_timing_ctrl
